// *** design/host_port.sv ***
// Host processor bus port: 8-bit slave for the separate-bus or multiplexed-bus host.
// Assumes the host clock is a slow pin (far below the core clock) that is sampled, not used as a clock,
// and that user logic on the core clock answers each user_start with user_finish.
module host_port
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic                             i_core_clk,
  input  wire logic                             i_arst_n,
  // Bus personality: 1 selects the multiplexed bus
  input  wire logic                             i_mode_mux,
  // Host pins
  input  wire logic                             i_host_interface_clock,
  input  wire logic                             i_start_strobe_pin_n,
  input  wire logic                             i_select_low_n,
  input  wire logic                             i_select_high,
  input  wire logic                             i_direction_select,
  input  wire logic                             i_addr_capture_pin,
  input  wire logic                             i_byte_en0,
  input  wire logic                             i_byte_en1,
  input  wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0] i_data,
  output logic      [host_port_pkg::DATA_W-1:0] o_data,
  output logic                                  o_data_oe,
  output logic                                  o_host_acknowledge_n,
  output logic                                  o_burst_block_pin_n,
  output logic                                  o_host_interrupt_n,
  // User logic side
  output logic      [host_port_pkg::ADDR_W-1:0] o_user_addr,
  output logic                                  o_user_read,
  output logic                                  o_user_start,
  output logic      [host_port_pkg::DATA_W-1:0] o_user_wdata,
  output logic                                  o_irq_pending,
  input  wire logic                             i_user_finish,
  input  wire logic [host_port_pkg::DATA_W-1:0] i_user_rdata,
  input  wire logic                             i_user_irq_n
);
  import host_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a bit changes once stages two and three agree
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] next_pins;
  logic             hclk_prev;

  assign pins_raw = {i_host_interface_clock, i_start_strobe_pin_n, i_select_low_n, i_select_high,
                     i_direction_select, i_addr_capture_pin, i_byte_en1, i_byte_en0, i_addr, i_data};

  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_agree
      assign next_pins[g] = (sync2[g] == sync3[g]) ? sync3[g] : pins[g];
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1     <= PIN_RESET;
      sync2     <= PIN_RESET;
      sync3     <= PIN_RESET;
      pins      <= PIN_RESET;
      hclk_prev <= 1'b0;
    end else begin
      sync1     <= pins_raw;
      sync2     <= sync1;
      sync3     <= sync2;
      pins      <= next_pins;
      hclk_prev <= pins[P_HCLK];
    end
  end

  // All filtered pins share the same delay, so they are seen as they stood at the host edge
  logic host_rise;
  logic host_fall;
  assign host_rise = pins[P_HCLK] & ~hclk_prev;
  assign host_fall = ~pins[P_HCLK] & hclk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  port_state_t       state;
  port_state_t       next_state;
  logic [ADDR_W-1:0] mux_addr;
  logic [ADDR_W-1:0] next_mux_addr;
  logic [ADDR_W-1:0] next_user_addr;
  logic              next_user_read;
  logic              next_user_start;
  logic [DATA_W-1:0] next_user_wdata;
  logic [DATA_W-1:0] next_data;
  logic              next_data_oe;
  logic              next_ack_n;
  logic              selected;
  logic              start_seen;
  logic              host_read;

  assign selected   = ~pins[P_SEL_LO] & pins[P_SEL_HI];
  assign start_seen = host_rise & ~pins[P_STRB] & selected;
  assign host_read  = i_mode_mux ? ~pins[P_DIR] : pins[P_DIR];

  always_comb begin
    next_state      = state;
    next_mux_addr   = mux_addr;
    next_user_addr  = o_user_addr;
    next_user_read  = o_user_read;
    next_user_start = o_user_start;
    next_user_wdata = o_user_wdata;
    next_data       = o_data;
    next_data_oe    = o_data_oe;
    next_ack_n      = o_host_acknowledge_n;
    // address capture on host falling edge
    if (host_fall && pins[P_ALE]) begin
      next_mux_addr = pins[P_DATA +: ADDR_W];
    end
    case (state)
      ST_IDLE: begin
        next_ack_n   = ACK_IDLE;
        next_data_oe = 1'b0;
        if (start_seen) begin
          next_user_read = host_read;
          if (i_mode_mux) begin
            // byte enables as low address bits
            next_user_addr = {mux_addr[ADDR_W-1:2], pins[P_BE1], pins[P_BE0]};
          end else begin
            next_user_addr = pins[P_ADDR +: ADDR_W];
          end
          if (host_read) begin
            next_user_start = 1'b1;
            next_state      = ST_USER;
          end else begin
            next_state = ST_WDATA;
          end
        end
      end
      ST_WDATA: begin
        // write data at next rising edge
        if (host_rise) begin
          next_user_wdata = pins[P_DATA +: DATA_W];
          next_user_start = 1'b1;
          next_state      = ST_USER;
        end
      end
      ST_USER: begin
        if (i_user_finish) begin
          next_user_start = 1'b0;
          if (o_user_read) begin
            next_data    = i_user_rdata;
            next_data_oe = 1'b1;
          end
          next_state = ST_ARM;
        end
      end
      ST_ARM: begin
        // read data already driven before the acknowledge edge
        if (host_rise) begin
          next_ack_n = ~ACK_IDLE;
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        // acknowledge lasts exactly one host cycle
        if (host_rise) begin
          next_ack_n   = ACK_IDLE;
          next_data_oe = 1'b0;
          next_state   = ST_IDLE;
        end
      end
      default: begin
        next_state      = ST_IDLE;
        next_ack_n      = ACK_IDLE;
        next_data_oe    = 1'b0;
        next_user_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state                <= ST_IDLE;
      mux_addr             <= ADDR_RESET;
      o_user_addr          <= ADDR_RESET;
      o_user_read          <= 1'b0;
      o_user_start         <= 1'b0;
      o_user_wdata         <= DATA_RESET;
      o_data               <= DATA_RESET;
      o_data_oe            <= 1'b0;
      o_host_acknowledge_n <= ACK_IDLE;
      o_burst_block_pin_n  <= ACK_IDLE;
    end else begin
      state                <= next_state;
      mux_addr             <= next_mux_addr;
      o_user_addr          <= next_user_addr;
      o_user_read          <= next_user_read;
      o_user_start         <= next_user_start;
      o_user_wdata         <= next_user_wdata;
      o_data               <= next_data;
      o_data_oe            <= next_data_oe;
      o_host_acknowledge_n <= next_ack_n;
      // burst inhibit only in separate-bus mode, with the acknowledge
      o_burst_block_pin_n  <= i_mode_mux ? ACK_IDLE : next_ack_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt forwarding; user request is core-domain logic, so one register suffices
  logic next_irq_n;
  assign next_irq_n = i_user_irq_n;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_host_interrupt_n <= IRQ_IDLE_N;
      o_irq_pending      <= 1'b0;
    end else begin
      // held while the user request stands
      o_host_interrupt_n <= next_irq_n;
      o_irq_pending      <= ~next_irq_n;
    end
  end

endmodule : host_port

// *** design/host_port_pkg.sv ***
// Constants, state encoding and pin packing for the host processor bus port.
// Assumes one core clock domain; every host pin, host clock included, is asynchronous to it.
//
// Behaviour
// - In separate-bus mode a transfer is taken only with select_low_n low, select_high high and the 5-bit address.
// - In separate-bus mode write data is sampled at the host rising edge after the cycle with xfer_begin_n low.
// - In separate-bus mode xfer_done_n goes low for exactly one host cycle, with no_burst_n low beside it.
// - For reads in both modes the read data is on the data pins at the edge where the acknowledge is low.
// - The user interrupt request is forwarded active low and as a status level until the user withdraws it.
// - In multiplexed mode the address is captured from D[4:0] at a host falling edge while addr_capture is high.
// - In multiplexed mode write data is sampled at the rising edge of the cycle after strobe_start_n went low.
// - In multiplexed mode ready_recover_n is driven low for only one host cycle per transfer.
// - In multiplexed mode the direction input means write when high and read when low.
// - In multiplexed 8-bit operation byte_en0 is address bit 0 and byte_en1 is address bit 1.
// - The host cycle is stretched until user logic raises user_finish, and only then acknowledged.
package host_port_pkg;

  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 8;
  // Packed pin vector: data, address, then single control pins
  localparam int PIN_W     = 21;
  localparam int P_DATA    = 0;
  localparam int P_ADDR    = 8;
  localparam int P_BE0     = 13;
  localparam int P_BE1     = 14;
  localparam int P_ALE     = 15;
  localparam int P_DIR     = 16;
  localparam int P_SEL_HI  = 17;
  localparam int P_SEL_LO  = 18;
  localparam int P_STRB    = 19;
  localparam int P_HCLK    = 20;

  // Pin idle values seen after reset: strobes and low selects high
  localparam logic [PIN_W-1:0]  PIN_RESET   = 21'h0C0000;
  localparam logic              ACK_IDLE    = 1'b1;
  localparam logic              IRQ_IDLE_N  = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WDATA = 3'b001,
    ST_USER  = 3'b010,
    ST_ARM   = 3'b011,
    ST_ACK   = 3'b100
  } port_state_t;

endpackage : host_port_pkg

// *** sim/host_port_checker.sv ***
// Checker for the host port, bound to its top-level ports.
// Assumes one core clock domain; host pins are slow and sampled.
module host_port_checker (
  // Clock, reset, mode
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_mode_mux,
  // Host pins
  input wire logic i_select_low_n,
  input wire logic i_select_high,
  input wire logic i_direction_select,
  input wire logic o_host_acknowledge_n,
  input wire logic o_burst_block_pin_n,
  input wire logic o_host_interrupt_n,
  input wire logic o_data_oe,
  // User side
  input wire logic o_user_read,
  input wire logic o_user_start,
  input wire logic o_irq_pending,
  input wire logic i_user_finish,
  input wire logic i_user_irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  wire ack = o_host_acknowledge_n;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_ack_one_cycle: assert property ($fell(ack) |-> !ack [*6] ##[1:4] ack) else $error("ack length");
  a_burst_with_ack: assert property (!i_mode_mux |-> o_burst_block_pin_n == ack) else $error("burst");
  a_mux_no_burst: assert property (i_mode_mux |-> o_burst_block_pin_n) else $error("mux burst");
  a_irq_follow: assert property ((o_host_interrupt_n == $past(i_user_irq_n)) && (o_irq_pending == !o_host_interrupt_n))
    else $error("irq");
  a_wait_user: assert property (o_user_start |-> ack) else $error("early ack");
  a_start_drop: assert property (o_user_start && i_user_finish |=> !o_user_start) else $error("start");
  a_read_drive: assert property ($fell(ack) && o_user_read |-> o_data_oe) else $error("read data");
  a_sel_taken: assert property ($rose(o_user_start) |-> !i_select_low_n && i_select_high) else $error("sel");
  a_dir_sense: assert property ($rose(o_user_start) |-> o_user_read == (i_direction_select ^ i_mode_mux))
    else $error("dir");
  c_mux_write: cover property ($rose(o_user_start) && i_mode_mux && !o_user_read);
  c_sep_read: cover property ($fell(ack) && !i_mode_mux && o_user_read);
  c_irq: cover property ($fell(o_host_interrupt_n));
endmodule : host_port_checker

bind host_port host_port_checker host_port_checker_inst (.*);

// *** sim/host_model.sv ***
// Host processor model: free host clock, single-byte cycles.
// Assumes the bench calls xfer only while the port is idle.
module host_model
  import host_port_pkg::*;
(
  // Core clock, bus mode and port outputs
  input  wire logic              i_core_clk,
  input  wire logic              i_mode_mux,
  input  wire logic              o_host_acknowledge_n,
  input  wire logic              o_data_oe,
  input  wire logic [DATA_W-1:0] o_data,
  // Host pins
  output logic                   i_host_interface_clock,
  output logic                   i_start_strobe_pin_n,
  output logic                   i_select_low_n,
  output logic                   i_select_high,
  output logic                   i_direction_select,
  output logic                   i_addr_capture_pin,
  output logic                   i_byte_en0,
  output logic                   i_byte_en1,
  output logic      [ADDR_W-1:0] i_addr,
  output wire logic [DATA_W-1:0] i_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0]        ph;
  logic [DATA_W-1:0] hd;
  assign i_data = o_data_oe ? o_data : hd;
  initial begin
    {ph, hd, i_host_interface_clock, i_select_high, i_direction_select} = '0;
    {i_addr_capture_pin, i_byte_en0, i_byte_en1, i_addr} = '0;
    {i_start_strobe_pin_n, i_select_low_n} = 2'h3;
  end
  // Eight core cycles per host period; pins move mid high phase
  always @(posedge i_core_clk) begin
    ph <= ph + 3'h1;
    i_host_interface_clock <= !ph[2];
  end
  task automatic step();
    do @(posedge i_core_clk); while (ph != 3'h2);
  endtask : step
  task automatic xfer(input logic sel, rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rv, output logic ok);
    step();
    if (i_mode_mux) begin
      // Low data bits differ from the byte enables, so the source of each address bit shows
      hd <= {3'h0, a[ADDR_W-1:2], ~a[1:0]};
      i_addr_capture_pin <= 1'b1;
      step();
      i_addr_capture_pin <= 1'b0;
      {i_byte_en1, i_byte_en0} <= a[1:0];
    end
    // Separate address pins carry a decoy in mux mode
    i_addr <= i_mode_mux ? ~a : a;
    i_select_low_n <= !sel;
    i_select_high <= sel;
    i_direction_select <= rd ^ i_mode_mux;
    i_start_strobe_pin_n <= 1'b0;
    step();
    i_start_strobe_pin_n <= 1'b1;
    hd <= rd ? ~hd : wd;
    ok = 1'b0;
    rv = '0;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge i_core_clk);
      if (ph == 3'h0 && !o_host_acknowledge_n) begin
        ok = 1'b1;
        rv = i_data;
      end
    end
    step();
    {i_select_low_n, i_select_high} <= 2'h2;
    i_addr <= ~a;
    hd <= ~hd;
  endtask : xfer
endmodule : host_model

// *** sim/tb_top.sv ***
// Bench for the host port: host model, user responder, directed scenarios.
// Assumes the checker binds itself from its own file.
module tb_top;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk, i_arst_n, i_mode_mux, i_host_interface_clock, i_start_strobe_pin_n, i_select_low_n;
  logic i_select_high, i_direction_select, i_addr_capture_pin, i_byte_en0, i_byte_en1, i_user_finish;
  logic o_data_oe, o_host_acknowledge_n, o_burst_block_pin_n, o_host_interrupt_n, o_user_read;
  logic o_user_start, o_irq_pending, i_user_irq_n, ok;
  logic [ADDR_W-1:0] i_addr, o_user_addr;
  logic [DATA_W-1:0] o_data, o_user_wdata, i_user_rdata, rv;
  wire  [DATA_W-1:0] i_data;
  int failures = 0, comparisons = 0, cyc = 0, uc = 0, udel = 0;
  host_port host_port_inst (.*);
  host_model host_model_inst (.*);
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // User logic answers after udel cycles; data is made from the address
  always @(posedge i_core_clk) begin
    uc <= o_user_start ? uc + 1 : 0;
    i_user_finish <= o_user_start && uc == udel && !i_user_finish;
    i_user_rdata <= {3'h5, o_user_addr};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic reset_dut(input logic mux);
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    i_mode_mux <= mux;
    repeat (8) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (8) @(posedge i_core_clk);
  endtask : reset_dut
  // Back-to-back write then read on the separate bus
  task automatic t_sep();
    host_model_inst.xfer(1'b1, 1'b0, 5'h13, 8'hC3, rv, ok);
    chk({ok, o_user_addr}, 6'h33);
    chk({o_user_read, o_user_wdata}, 9'h0C3);
    host_model_inst.xfer(1'b1, 1'b1, 5'h0A, 8'h00, rv, ok);
    chk({ok, o_user_read, rv}, 10'h3AA);
  endtask : t_sep
  // Unselected strobe must leave the port untouched
  task automatic t_unsel();
    host_model_inst.xfer(1'b0, 1'b0, 5'h01, 8'h11, rv, ok);
    chk({ok, o_user_addr}, 6'h0A);
  endtask : t_unsel
  task automatic t_irq();
    i_user_irq_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk({o_host_interrupt_n, o_irq_pending}, 2'h1);
    i_user_irq_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk({o_host_interrupt_n, o_irq_pending}, 2'h2);
  endtask : t_irq
  // Multiplexed bus, slow user logic on the write
  task automatic t_mux();
    udel = 40;
    host_model_inst.xfer(1'b1, 1'b0, 5'h1E, 8'h5A, rv, ok);
    chk({ok, o_user_read, o_user_addr}, 7'h5E);
    chk(o_user_wdata, 8'h5A);
    udel = 0;
    host_model_inst.xfer(1'b1, 1'b1, 5'h07, 8'h00, rv, ok);
    chk({ok, o_user_read, rv}, 10'h3A7);
  endtask : t_mux
  initial begin
    i_arst_n = 1'b0;
    i_mode_mux = 1'b0;
    i_user_irq_n = 1'b1;
    i_user_finish = 1'b0;
    i_user_rdata = '0;
    reset_dut(1'b0);
    t_sep();
    t_unsel();
    t_irq();
    reset_dut(1'b1);
    t_mux();
    close_out();
  end
endmodule : tb_top
